// File: design/psa_aggregator.sv
/*
 * PCI slot interrupt aggregator: twelve slot interrupt inputs, pending and
 * mask registers on the host local bus, one combined active-low request,
 * and the abort push-button non-maskable request driver.
 * Assumes the host bus signals are synchronous to clk; slot lines and the
 * push-button are asynchronous and are synchronised here.
 */
`timescale 1ns/100ps
module psa_aggregator
    import psa_pkg::*;
#(
    parameter int NUM_SLOTS = PSA_NUM_SLOTS,
    parameter int LINES     = PSA_LINES
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [PSA_SRC_W-1:0]  slot_int_n,
    input  wire logic                  aggregator_chip_select_n,
    input  wire logic                  bus_we_n,
    input  wire logic [PSA_ADDR_W-1:0] bus_addr,
    input  wire logic [PSA_DATA_W-1:0] bus_wdata,
    output logic [PSA_DATA_W-1:0]      bus_rdata,
    output logic                       bus_rvalid,
    output logic                       aggregate_request_line_n,
    output logic [1:0]                 irq_slot,
    input  wire logic                  abort_button_n,
    output logic                       abort_nmi_request_line_o,
    output logic                       abort_nmi_request_line_oe_n
);

    localparam int SRC = NUM_SLOTS * LINES;

    generate
        if (SRC != PSA_SRC_W || NUM_SLOTS > 4 || LINES < 1) begin : g_chk
            $error("psa_aggregator: slot or line count not supported");
        end
    endgenerate

    typedef struct packed {
        logic [SRC-1:0]        sync1;
        logic [SRC-1:0]        sync2;
        logic                  btn1;
        logic                  btn2;
        logic [SRC-1:0]        pending;
        logic [SRC-1:0]        mask;
        logic [PSA_DATA_W-1:0] rdata;
        logic                  rvalid;
        logic                  req_n;
        logic [1:0]            slot;
    } psa_state_t;

    psa_state_t st_q;
    psa_state_t st_d;

    logic [LINES-1:0] line_act;
    logic [SRC-1:0]   set_vec;
    logic [SRC-1:0]   clr_vec;
    logic [SRC-1:0]   live_vec;
    logic             any_live;
    logic [1:0]       win_slot;
    logic             sel;
    logic             wr_pend;
    logic             wr_mask;
    logic             rd_acc;

    // Each board line is the wire-OR of the same letter from every slot
    genvar gl;
    genvar gb;
    generate
        for (gl = 0; gl < LINES; gl++) begin : g_line
            logic [NUM_SLOTS-1:0] per_slot;
            for (gb = 0; gb < NUM_SLOTS; gb++) begin : g_or
                assign per_slot[gb]            = st_q.sync2[gb*LINES + gl];
                assign set_vec[gb*LINES + gl]  = line_act[gl]
                                               & ~st_q.mask[gb*LINES + gl];
            end
            assign line_act[gl] = |per_slot;
        end
    endgenerate

    assign sel      = ~aggregator_chip_select_n;
    assign wr_pend  = sel && !bus_we_n && bus_addr == PSA_PEND_OFS;
    assign wr_mask  = sel && !bus_we_n && bus_addr == PSA_MASK_OFS;
    assign rd_acc   = sel && bus_we_n;
    // Write-one-to-clear lets software drop the spurious copies
    assign clr_vec  = wr_pend ? bus_wdata[SRC-1:0] : '0;
    assign live_vec = st_q.pending & ~st_q.mask;

    psa_slot_prio #(
        .NUM_SLOTS (NUM_SLOTS),
        .LINES     (LINES)
    ) u_prio (
        .active     (live_vec),
        .any_active (any_live),
        .win_slot   (win_slot)
    );

    always_comb begin
        st_d       = st_q;
        // Inputs are active low; invert once here so stage two holds active-high
        st_d.sync1 = ~slot_int_n;
        st_d.sync2 = st_q.sync1;
        st_d.btn1  = ~abort_button_n;
        st_d.btn2  = st_q.btn1;
        // Set is level based: a line held active keeps re-setting its bits,
        // so the requesting device must be quieted before its copies are cleared
        // A set arriving with its clear survives so no request is lost
        st_d.pending = (st_q.pending & ~clr_vec) | set_vec;
        if (wr_mask) begin
            st_d.mask = bus_wdata[SRC-1:0];
        end
        st_d.rvalid = rd_acc;
        st_d.rdata  = PSA_UNMAPPED;
        if (rd_acc) begin
            case (bus_addr)
                PSA_PEND_OFS: st_d.rdata = {PSA_RSVD_VAL, st_q.pending};
                PSA_MASK_OFS: st_d.rdata = {PSA_RSVD_VAL, st_q.mask};
                default:      st_d.rdata = PSA_UNMAPPED;
            endcase
        end
        st_d.req_n = ~any_live;
        st_d.slot  = win_slot;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q         <= '0;
            st_q.pending <= PSA_PEND_RST;
            st_q.mask    <= PSA_MASK_RST;
            st_q.req_n   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus_rdata                = st_q.rdata;
    assign bus_rvalid               = st_q.rvalid;
    assign aggregate_request_line_n = st_q.req_n;
    assign irq_slot                 = st_q.slot;
    // Open-drain: only ever pull low; the host gates acceptance by its enable bit
    assign abort_nmi_request_line_o    = 1'b0;
    assign abort_nmi_request_line_oe_n = ~st_q.btn2;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Slot line path, register reads and writes, abort drive
    pending_set_a: assert property (
        |set_vec |=> ((st_q.pending & $past(set_vec)) == $past(set_vec)))
        else $error("unmasked line did not set pending bits");

    masked_hold_a: assert property (
        1'b1 |=> ((st_q.pending & $past(~st_q.pending & st_q.mask)) == '0))
        else $error("masked source set a pending bit");

    three_bits_a: assert property (
        (line_act[0] && st_q.mask == '0) |=>
            (st_q.pending[0] && st_q.pending[LINES] && st_q.pending[2*LINES]))
        else $error("line A did not set one bit per slot");

    req_assert_a: assert property (
        |live_vec |=> !aggregate_request_line_n)
        else $error("aggregate request missing");

    req_release_a: assert property (
        (live_vec == '0) |=> aggregate_request_line_n)
        else $error("aggregate request stuck");

    read_pend_a: assert property (
        (rd_acc && bus_addr == PSA_PEND_OFS) |=>
            (bus_rvalid && bus_rdata == {PSA_RSVD_VAL, $past(st_q.pending)}))
        else $error("pending read wrong");

    mask_write_a: assert property (
        wr_mask |=> (st_q.mask == $past(bus_wdata[SRC-1:0])))
        else $error("mask write lost");

    no_select_a: assert property (
        aggregator_chip_select_n |=> ($stable(st_q.mask) && !bus_rvalid))
        else $error("register changed without chip select");

    rsvd_zero_a: assert property (
        bus_rdata[PSA_DATA_W-1:SRC] == '0)
        else $error("reserved bits not zero");

    set_wins_a: assert property (
        (wr_pend && (set_vec & bus_wdata[SRC-1:0]) != '0) |=>
            ((st_q.pending & $past(set_vec)) == $past(set_vec)))
        else $error("clear beat a simultaneous set");

    slot_prio_a: assert property (
        (|live_vec[LINES-1:0]) |=> (irq_slot == 2'h0))
        else $error("slot 0 did not win");

    abort_drive_a: assert property (
        (!abort_button_n [*3]) |-> !abort_nmi_request_line_oe_n)
        else $error("abort button not driven onto the request line");

    // Register bus: reads are free of side effects, strobes last one cycle
    rvalid_idle_a: assert property (
        !rd_acc |=> (!bus_rvalid && bus_rdata == '0))
        else $error("read strobe without a read");

    no_write_read_a: assert property (
        (sel && !bus_we_n) |=> !bus_rvalid)
        else $error("write cycle raised the read strobe");

    read_mask_a: assert property (
        (rd_acc && bus_addr == PSA_MASK_OFS) |=>
            (bus_rvalid && bus_rdata == {PSA_RSVD_VAL, $past(st_q.mask)}))
        else $error("mask read wrong");

    read_unmapped_a: assert property (
        (rd_acc && bus_addr != PSA_PEND_OFS && bus_addr != PSA_MASK_OFS) |=>
            (bus_rvalid && bus_rdata == PSA_UNMAPPED))
        else $error("unmapped read returned data");

    read_side_effect_a: assert property (
        rd_acc |=> ($stable(st_q.mask)
            && ((st_q.pending & $past(st_q.pending)) == $past(st_q.pending))))
        else $error("read disturbed register state");

    mask_hold_a: assert property (
        !wr_mask |=> $stable(st_q.mask))
        else $error("mask changed without a write");

    unmapped_write_a: assert property (
        (sel && !bus_we_n && bus_addr != PSA_PEND_OFS && bus_addr != PSA_MASK_OFS)
            |=> $stable(st_q.mask))
        else $error("unmapped write reached the mask");

    // Pending path: bits only move by a set or by a clear
    pend_clear_a: assert property (
        wr_pend |=> ((st_q.pending & $past(clr_vec & ~set_vec)) == '0))
        else $error("pending bit survived its clear");

    pend_sticky_a: assert property (
        !wr_pend |=> ((st_q.pending & $past(st_q.pending)) == $past(st_q.pending)))
        else $error("pending bit dropped without a clear");

    pend_source_a: assert property (
        1'b1 |=> ((st_q.pending & ~$past(st_q.pending | set_vec)) == '0))
        else $error("pending bit set without a source");

    input_latency_a: assert property (
        (!slot_int_n[0] && st_q.mask[0] == 1'b0) [*3] |=> st_q.pending[0])
        else $error("slot line not taken after two sync stages");

    line_quiet_a: assert property (
        (slot_int_n == '1) [*2] |=> (set_vec == '0))
        else $error("quiet slot lines still setting bits");

    generate
        for (gl = 0; gl < LINES; gl++) begin : g_line_chk
            line_fanout_a: assert property (
                (line_act[gl] && st_q.mask == '0) |=> (st_q.pending[gl]
                    && st_q.pending[LINES + gl] && st_q.pending[2*LINES + gl]))
                else $error("shared line did not set one bit per slot");
        end
    endgenerate

    // Priority and combined request
    slot1_prio_a: assert property (
        (live_vec[LINES-1:0] == '0 && |live_vec[LINES +: LINES]) |=>
            (irq_slot == 2'h1))
        else $error("slot 1 did not win over slot 2");

    slot2_prio_a: assert property (
        (live_vec[2*LINES-1:0] == '0 && |live_vec[2*LINES +: LINES]) |=>
            (irq_slot == 2'h2))
        else $error("slot 2 request not reported");

    slot_idle_a: assert property (
        (live_vec == '0) |=> (irq_slot == 2'h0))
        else $error("slot reported with nothing live");

    pend_masked_req_a: assert property (
        (live_vec == '0 && st_q.pending != '0) |=> aggregate_request_line_n)
        else $error("masked pending bit raised the request");

    // Abort line: two sync stages each way
    abort_release_a: assert property (
        (abort_button_n [*3]) |-> abort_nmi_request_line_oe_n)
        else $error("abort request line held without button");

    abort_sync_a: assert property (
        $fell(abort_button_n) |=> abort_nmi_request_line_oe_n)
        else $error("abort button bypassed its synchroniser");

    // Reset values, checked with the reset disable lifted
    reset_values_a: assert property (@(posedge clk) disable iff (1'b0)
        !rst_n |=> (st_q.pending == '0 && st_q.mask == '0 && !bus_rvalid
            && aggregate_request_line_n && abort_nmi_request_line_oe_n))
        else $error("state not cleared by reset");

    multi_slot_c: cover property (
        |live_vec[LINES-1:0] && |live_vec[2*LINES +: LINES]);
    clear_spur_c: cover property (wr_pend ##1 !aggregate_request_line_n);
    abort_c: cover property ($fell(abort_nmi_request_line_oe_n));
    slot1_win_c: cover property (irq_slot == 2'h1 && !aggregate_request_line_n);
    set_wins_c: cover property (
        wr_pend && (set_vec & bus_wdata[SRC-1:0]) != '0);

endmodule // psa_aggregator

// File: design/psa_pkg.sv
/*
 * Constants for the PCI slot interrupt aggregator: register offsets,
 * field layout and reset values.
 * Assumes a 32-bit host bus with byte addresses inside the chip-select region.
 */
// Overview of operation
// - Accept twelve slot interrupt lines, three slots.
// - Combine unmasked pending bits into one request.
// - Registers answer only under own chip select.
// - Fixed slot priority, slot 0 highest.
// - One shared line sets three slot bits.
// - Pending register at offset 0x0, side-effect-free read.
// - Pending bits: slot*4 plus line, reset zero.
// - Mask register at offset 0x4, read/write.
// - Mask one blocks source, resets to zero.
// - Bits 12 to 31 unimplemented, reserved.
// - Abort button asserts low non-maskable request.
package psa_pkg;

    localparam int          PSA_DATA_W      = 32;
    localparam int          PSA_ADDR_W      = 3;
    localparam int          PSA_NUM_SLOTS   = 3;
    localparam int          PSA_LINES       = 4;
    localparam int          PSA_SRC_W       = PSA_NUM_SLOTS * PSA_LINES;

    localparam logic [2:0]  PSA_PEND_OFS    = 3'h0;
    localparam logic [2:0]  PSA_MASK_OFS    = 3'h4;

    localparam logic [11:0] PSA_PEND_RST    = 12'h000;
    localparam logic [11:0] PSA_MASK_RST    = 12'h000;
    localparam logic [19:0] PSA_RSVD_VAL    = 20'h00000;
    localparam logic [31:0] PSA_UNMAPPED    = 32'h00000000;

endpackage : psa_pkg

// File: design/psa_slot_prio.sv
/*
 * Fixed-priority slot selector: reports whether any slot has an active
 * source and the index of the winning slot (lowest index wins).
 * Assumes a purely combinational use on the main clock.
 */
`timescale 1ns/100ps
module psa_slot_prio
    import psa_pkg::*;
#(
    parameter int NUM_SLOTS = PSA_NUM_SLOTS,
    parameter int LINES     = PSA_LINES
) (
    input  wire logic [NUM_SLOTS*LINES-1:0] active,
    output logic                            any_active,
    output logic [1:0]                      win_slot
);

    // The winning index is two bits wide, so more than four slots cannot be named
    generate
        if (NUM_SLOTS < 1 || NUM_SLOTS > 4 || LINES < 1) begin : g_chk
            $error("psa_slot_prio: slot or line count not supported");
        end
    endgenerate

    logic [NUM_SLOTS-1:0] slot_act;

    genvar gs;
    generate
        for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot
            assign slot_act[gs] = |active[gs*LINES +: LINES];
        end
    endgenerate

    // Walk from the highest slot down so the lowest active slot wins
    always_comb begin
        win_slot = 2'h0;
        for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
            if (slot_act[s]) begin
                win_slot = 2'(s);
            end
        end
    end

    assign any_active = |slot_act;

endmodule // psa_slot_prio

// File: sim/psa_slot_model.sv
/*
 * Far side of the aggregator: slot boards on the shared interrupt lines and
 * off-board logic sharing the abort request line.
 * Assumes pull-ups on every line, so a released line reads high.
 */
`timescale 1ns/100ps
module psa_slot_model (
    input  wire logic [11:0] slot_req,
    input  wire logic        abort_ext_n,
    input  wire logic        nmi_o,
    input  wire logic        nmi_oe_n,
    input  wire logic        uni_req,
    input  wire logic        phy_req,
    output logic [11:0]      slot_int_n,
    output logic             nmi_line,
    output logic             uni_request_output_n,
    output logic             shared_phy_uni_request_line_n
);
    // Source flag the host reads back to tell the two requesters apart
    assign uni_request_output_n          = ~uni_req;
    // Open-drain requesters wire-AND onto the shared line
    assign shared_phy_uni_request_line_n = uni_request_output_n & ~phy_req;
    // Slot boards only pull low, never drive high
    assign slot_int_n = ~slot_req;
    // Wired-AND of open-drain drivers on the abort line
    assign nmi_line   = abort_ext_n & (nmi_oe_n | nmi_o);
endmodule // psa_slot_model

// File: sim/tb.sv
/*
 * Self-checking bench for the slot interrupt aggregator.
 * Assumes psa_pkg, the aggregator and the slot model are compiled first.
 */
`timescale 1ns/100ps
module tb;
    import psa_pkg::*;
    logic        clk       = 1'b0;
    logic        rst_n     = 1'b0;
    logic [11:0] slot_req  = 12'h000;
    logic        cs_n      = 1'b1;
    logic        we_n      = 1'b1;
    logic [2:0]  addr      = 3'h0;
    logic [31:0] wdata     = 32'h00000000;
    logic        btn_n     = 1'b1;
    logic        ext_n     = 1'b1;
    logic        uni_req   = 1'b0;
    logic        phy_req   = 1'b0;
    logic [11:0] slot_int_n;
    logic [31:0] rdata;
    logic [31:0] d;
    logic        rvalid;
    logic        req_n;
    logic        nmi_o;
    logic        nmi_oe_n;
    logic        nmi_line;
    logic [1:0]  irq_slot;
    logic        uni_n;
    logic        phy_uni_n;
    int          fails     = 0;
    int          cmp_count = 0;

    always #12.5 clk = ~clk;

    psa_aggregator dut (.clk(clk), .rst_n(rst_n), .slot_int_n(slot_int_n),
        .aggregator_chip_select_n(cs_n), .bus_we_n(we_n), .bus_addr(addr),
        .bus_wdata(wdata), .bus_rdata(rdata), .bus_rvalid(rvalid),
        .aggregate_request_line_n(req_n), .irq_slot(irq_slot),
        .abort_button_n(btn_n), .abort_nmi_request_line_o(nmi_o),
        .abort_nmi_request_line_oe_n(nmi_oe_n));
    psa_slot_model u_model (.slot_req(slot_req), .abort_ext_n(ext_n), .nmi_o(nmi_o),
        .nmi_oe_n(nmi_oe_n), .uni_req(uni_req), .phy_req(phy_req),
        .slot_int_n(slot_int_n), .nmi_line(nmi_line), .uni_request_output_n(uni_n),
        .shared_phy_uni_request_line_n(phy_uni_n));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [31:0] v);
        @(negedge clk);
        cs_n  = 1'b0;
        we_n  = 1'b0;
        addr  = a;
        wdata = v;
        @(negedge clk);
        cs_n  = 1'b1;
        we_n  = 1'b1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [31:0] v);
        @(negedge clk);
        cs_n = 1'b0;
        addr = a;
        @(negedge clk);
        cs_n = 1'b1;
        chk(rvalid, 32'h00000001);
        v = rdata;
    endtask

    task automatic t_regs();
        rd(3'h0, d);
        chk(d, 32'h00000000);
        rd(3'h4, d);
        chk(d, 32'h00000000);
        chk(req_n, 32'h00000001);
        wr(3'h4, 32'hFFFFFFFF);
        rd(3'h4, d);
        chk(d, 32'h00000FFF);
        // Write cycle without select must be ignored
        @(negedge clk);
        we_n  = 1'b0;
        wdata = 32'h00000000;
        @(negedge clk);
        we_n  = 1'b1;
        wr(3'h6, 32'h00000000);
        rd(3'h4, d);
        chk(d, 32'h00000FFF);
        rd(3'h2, d);
        chk(d, 32'h00000000);
        wr(3'h4, 32'h00000000);
        rd(3'h4, d);
        chk(d, 32'h00000000);
    endtask

    task automatic t_lines();
        for (int l = 0; l < 4; l++) begin
            @(negedge clk);
            slot_req[4 * (l % 3) + l] = 1'b1;
            repeat (6) @(negedge clk);
            rd(3'h0, d);
            chk(d, 32'h00000111 << l);
            chk(req_n, 32'h00000000);
            chk(irq_slot, 32'h00000000);
            rd(3'h0, d);
            chk(d, 32'h00000111 << l);
            slot_req = 12'h000;
            // Let the input synchronisers drain before clearing
            repeat (4) @(negedge clk);
            wr(3'h0, 32'h00000FFF);
            rd(3'h0, d);
            chk(d, 32'h00000000);
            chk(req_n, 32'h00000001);
        end
    endtask

    task automatic t_mask();
        wr(3'h4, 32'h00000022);
        slot_req[5] = 1'b1;
        repeat (6) @(negedge clk);
        rd(3'h0, d);
        chk(d, 32'h00000200);
        chk(irq_slot, 32'h00000002);
        chk(req_n, 32'h00000000);
        wr(3'h4, 32'h00000222);
        repeat (2) @(negedge clk);
        chk(req_n, 32'h00000001);
        wr(3'h4, 32'h00000202);
        repeat (4) @(negedge clk);
        chk(irq_slot, 32'h00000001);
        chk(req_n, 32'h00000000);
        // Clear a re-asserting bit and a masked one together
        wr(3'h0, 32'h00000220);
        rd(3'h0, d);
        chk(d, 32'h00000020);
        slot_req = 12'h000;
        repeat (4) @(negedge clk);
        wr(3'h0, 32'h00000FFF);
        wr(3'h4, 32'h00000000);
    endtask

    task automatic t_abort();
        btn_n = 1'b0;
        repeat (3) @(negedge clk);
        chk(nmi_oe_n, 32'h00000000);
        chk(nmi_line, 32'h00000000);
        chk(nmi_o, 32'h00000000);
        btn_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(nmi_line, 32'h00000001);
        ext_n = 1'b0;
        @(negedge clk);
        chk(nmi_line, 32'h00000000);
        chk(nmi_oe_n, 32'h00000001);
        ext_n = 1'b1;
    endtask

    task automatic t_shared();
        @(negedge clk);
        uni_req = 1'b1;
        @(negedge clk);
        chk(phy_uni_n, 32'h00000000);
        chk(uni_n, 32'h00000000);
        uni_req = 1'b0;
        phy_req = 1'b1;
        @(negedge clk);
        chk(phy_uni_n, 32'h00000000);
        chk(uni_n, 32'h00000001);
        chk(req_n, 32'h00000001);
        phy_req = 1'b0;
        @(negedge clk);
        chk(phy_uni_n, 32'h00000001);
    endtask

    task automatic t_reset();
        wr(3'h4, 32'h0000000F);
        slot_req[0] = 1'b1;
        repeat (6) @(negedge clk);
        chk(req_n, 32'h00000000);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n    = 1'b1;
        slot_req = 12'h000;
        chk(req_n, 32'h00000001);
        rd(3'h0, d);
        chk(d, 32'h00000000);
        rd(3'h4, d);
        chk(d, 32'h00000000);
    endtask

    task automatic report_and_stop();
        $display("fails %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Whole run is well under 1000 cycles
    initial begin
        #50000;
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        t_lines();
        t_mask();
        t_abort();
        t_shared();
        t_reset();
        report_and_stop();
    end
endmodule // tb
